// ### bench/interrupt_vector_priority_map_tb_top.sv
`timescale 1ns/1ps
bind ivp_interrupt_map ivp_chk u_chk (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src(src),
    .ext_pin_req_a(ext_pin_req_a), .ext_pin_req_b(ext_pin_req_b),
    .timer_a_overflow_flag(timer_a_overflow_flag), .timer_b_overflow_flag(timer_b_overflow_flag),
    .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_order(irq_order), .irq_high(irq_high), .in_service_hi(in_service_hi),
    .in_service_lo(in_service_lo)
);
module interrupt_vector_priority_map_tb_top;
    localparam logic [25:0] IDLE = 26'h0000020;
    localparam int ORD [26] = '{21, 20, 19, 17, 16, 15, 14, 14, 12, 12, 11, 11, 11, 11,
                                10, 9, 8, 7, 6, 6, 6, 6, 5, 5, 4, 4};
    localparam logic [7:0] WM [6] = '{8'hff, 8'h7f, 8'hbf, 8'hbf, 8'h77, 8'h77};
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [1:0]  pin = 2'h3;
    logic [1:0]  tmr = 2'h0;
    logic [25:0] srcv = IDLE;
    logic [7:0]  ack_wait = 8'h02;
    logic [7:0]  reg_rdata, d;
    logic        irq_ack, irq_return, irq_req, irq_high, in_service_hi, in_service_lo;
    logic [15:0] irq_vector;
    logic [4:0]  irq_order;
    int          error_cnt = 0;
    int          compares = 0;
    int          cyc = 0;
    int          i;
    ivp_interrupt_map DUT (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_pin_req_a(pin[0]), .ext_pin_req_b(pin[1]),
        .timer_a_overflow_flag(tmr[0]), .timer_b_overflow_flag(tmr[1]),
        .src(ivp_pkg::ivp_src_t'(srcv)), .irq_ack(irq_ack), .irq_return(irq_return),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_order(irq_order),
        .irq_high(irq_high), .in_service_hi(in_service_hi), .in_service_lo(in_service_lo)
    );
    ivp_core_model core (
        .clk(clk), .reset_n(reset_n), .irq_req(irq_req), .irq_vector(irq_vector),
        .ack_wait(ack_wait), .run_len(8'h0a), .irq_ack(irq_ack), .irq_return(irq_return),
        .took(), .took_vec()
    );
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[ERR] %0t run too long", $time);
            results();
        end
    end
    task results;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk_reg(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t data %h not %h", $time, got, exp);
        end
    endtask
    task chk_vec(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t vector %h not %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    function automatic logic [23:0] bm(input int o);
        return 24'h1 << (o < 7 ? o : o + 1);
    endfunction
    task en(input logic [23:0] m, input logic [23:0] h);
        for (int k = 0; k < 3; k++) begin
            wr(4'(2 * k), m[8 * k +: 8] | (k == 0 ? 8'h80 : 8'h00));
            wr(4'(2 * k + 1), h[8 * k +: 8]);
        end
    endtask
    task take(input int o);
        @(negedge clk);
        for (int n = 0; n < 80 && core.took !== 1'b1; n++) @(negedge clk);
        chk_vec(core.took === 1'b1 ? core.took_vec : 16'hffff, 16'h0003 + 16'(o * 8));
        @(posedge clk);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        for (i = 0; i < 16; i++) begin
            rd(4'(i));
            chk_reg(d, 8'h00);
        end
        for (i = 0; i < 6; i++) wr(4'(i), 8'hff);
        wr(4'ha, 8'hff);
        for (i = 0; i < 7; i++) begin
            rd(i < 6 ? 4'(i) : 4'ha);
            chk_reg(d, i < 6 ? WM[i] : 8'h00);
        end
        en(24'h0, 24'h0);
        wr(4'h0, 8'h00);
        @(posedge clk);
        tmr[0] <= 1'b1;
        @(posedge clk);
        tmr[0] <= 1'b0;
        rd(4'h6);
        chk_reg(d, 8'h02);
        wr(4'h6, 8'h02);
        rd(4'h6);
        chk_reg(d, 8'h00);
        for (i = 0; i < 4; i++) begin
            en(bm(i), 24'h0);
            @(posedge clk);
            if (i % 2) begin
                tmr[i / 2] <= 1'b1;
                @(posedge clk);
                tmr[i / 2] <= 1'b0;
            end else begin
                pin[i / 2] <= 1'b0;
                repeat (4) @(posedge clk);
                pin[i / 2] <= 1'b1;
            end
            take(i);
            repeat (20) @(negedge clk);
            rd(4'h6);
            chk_reg(d, 8'h00);
        end
        for (i = 0; i < 26; i++) begin
            en(bm(ORD[i]), 24'h0);
            srcv <= IDLE ^ (26'h1 << i);
            take(ORD[i]);
            take(ORD[i]);
            rd(4'(6 + ORD[i] / 8));
            chk_reg({7'h0, d[ORD[i] % 8]}, 8'h01);
            en(24'h0, 24'h0);
            srcv <= IDLE;
            repeat (30) @(negedge clk);
            chk_reg({7'h0, irq_req}, 8'h00);
        end
        en(bm(4) | bm(9) | bm(20), bm(20));
        srcv <= IDLE | 26'h2008000;
        take(4);
        srcv <= IDLE | 26'h0008000;
        take(9);
        srcv <= IDLE | 26'h0008002;
        take(20);
        @(negedge clk);
        chk_reg({6'h0, in_service_hi, in_service_lo}, 8'h03);
        @(posedge clk);
        srcv <= IDLE;
        repeat (40) @(posedge clk);
        srcv <= IDLE | 26'h2000002;
        take(20);
        srcv <= IDLE;
        repeat (40) @(posedge clk);
        ack_wait <= 8'hff;
        en(bm(4), 24'h0);
        srcv <= IDLE | 26'h2000000;
        repeat (6) @(posedge clk);
        reset_n <= 1'b0;
        @(negedge clk);
        chk_vec(irq_vector, 16'h0000);
        chk_reg({7'h0, irq_req}, 8'h00);
        @(posedge clk);
        reset_n <= 1'b1;
        rd(4'h0);
        chk_reg(d, 8'h00);
        results();
    end
endmodule

// ### bench/ivp_chk.sv
`timescale 1ns/1ps
`include "ivp_regs.svh"
module ivp_chk (
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire logic [`IVP_ADDR_W-1:0] reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    input wire logic                   ext_pin_req_a,
    input wire logic                   ext_pin_req_b,
    input wire logic                   timer_a_overflow_flag,
    input wire logic                   timer_b_overflow_flag,
    input wire ivp_pkg::ivp_src_t      src,
    input wire logic                   irq_ack,
    input wire logic                   irq_return,
    input wire logic                   irq_req,
    input wire logic [15:0]            irq_vector,
    input wire logic [`IVP_ORD_W-1:0]  irq_order,
    input wire logic                   irq_high,
    input wire logic                   in_service_hi,
    input wire logic                   in_service_lo
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_vec_order: assert property (irq_req |-> irq_vector == 16'h0003 + {irq_order, 3'h0})
        else $error("vector off its order");
    a_idle_vec: assert property (!irq_req |-> irq_vector == 16'h0000)
        else $error("vector without request");
    a_no_reserved: assert property (irq_req |-> irq_order != 5'd13 && irq_order != 5'd18)
        else $error("reserved slot requested");
    a_ack_drop: assert property (irq_req && irq_ack |=> !irq_req && (in_service_hi || in_service_lo))
        else $error("ack not taken");
    a_hi_entry: assert property (irq_req && irq_ack && irq_high |=> in_service_hi)
        else $error("high routine not entered");
    a_low_held: assert property (in_service_hi || in_service_lo |-> !irq_req || irq_high)
        else $error("low request during routine");
    a_high_held: assert property (in_service_hi |-> !irq_req)
        else $error("request during high routine");
    a_ret_hi: assert property (irq_return && in_service_hi |=> !in_service_hi)
        else $error("high routine not ended");
endmodule

// ### bench/ivp_core_model.sv
`timescale 1ns/1ps
module ivp_core_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    input  wire logic [7:0]  ack_wait,
    input  wire logic [7:0]  run_len,
    output      logic        irq_ack,
    output      logic        irq_return,
    output      logic        took,
    output      logic [15:0] took_vec
);
    logic [7:0] wcnt;
    logic [7:0] rcnt;
    logic [1:0] depth;
    logic       ret;
    assign ret = depth != 2'h0 && rcnt == 8'h00;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {irq_ack, irq_return, took, took_vec, wcnt, rcnt, depth} <= '0;
        end else begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            took <= 1'b0;
            if (irq_ack && irq_req) begin
                took <= 1'b1;
                took_vec <= irq_vector;
                depth <= depth + 2'h1;
                rcnt <= run_len;
                wcnt <= 8'h00;
            end else begin
                wcnt <= irq_req ? wcnt + 8'h01 : 8'h00;
                irq_ack <= irq_req && wcnt >= ack_wait && !ret;
                if (depth != 2'h0) begin
                    rcnt <= ret ? run_len : rcnt - 8'h01;
                end
                if (ret) begin
                    irq_return <= 1'b1;
                    depth <= depth - 2'h1;
                end
            end
        end
    end
endmodule

// ### core/ivp_interrupt_map.sv
`timescale 1ns/1ps
`include "ivp_regs.svh"

module ivp_interrupt_map (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic [`IVP_ADDR_W-1:0]    reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output      logic [7:0]                reg_rdata,
    input  wire logic                      ext_pin_req_a,
    input  wire logic                      ext_pin_req_b,
    input  wire logic                      timer_a_overflow_flag,
    input  wire logic                      timer_b_overflow_flag,
    input  wire ivp_pkg::ivp_src_t         src,
    input  wire logic                      irq_ack,
    input  wire logic                      irq_return,
    output      logic                      irq_req,
    output      logic [15:0]               irq_vector,
    output      logic [`IVP_ORD_W-1:0]     irq_order,
    output      logic                      irq_high,
    output      logic                      in_service_hi,
    output      logic                      in_service_lo
);

    ivp_pkg::ivp_state_t              st;
    ivp_pkg::ivp_state_t              next_st;

    logic [`IVP_NUM_SRC-1:0]          raw_req;
    logic [`IVP_NUM_SRC-1:0]          enable_vec;
    logic [`IVP_NUM_SRC-1:0]          level_vec;
    logic [`IVP_NUM_SRC-1:0]          cand;
    logic [`IVP_NUM_HW-1:0]           hw_set;
    logic [`IVP_NUM_HW-1:0]           hw_clr;
    logic                             fall_a;
    logic                             fall_b;
    logic                             found_hi;
    logic                             found_lo;
    logic [`IVP_ORD_W-1:0]            hi_idx;
    logic [`IVP_ORD_W-1:0]            lo_idx;
    logic                             grant;
    logic                             grant_high;
    logic [`IVP_ORD_W-1:0]            grant_idx;

    assign reg_rdata     = st.rdata;
    assign irq_req       = st.req;
    assign irq_vector    = st.vector;
    assign irq_order     = st.req_order;
    assign irq_high      = st.req_high;
    assign in_service_hi = st.act_hi;
    assign in_service_lo = st.act_lo;

    // pin requests are caught on the falling edge after two flops
    assign fall_a = st.prev_a & ~st.sync_a[1];
    assign fall_b = st.prev_b & ~st.sync_b[1];

    // events for the flags this block holds and clears itself
    always_comb begin
        hw_set    = '0;
        hw_set[0] = fall_a;
        hw_set[1] = timer_a_overflow_flag;
        hw_set[2] = fall_b;
        hw_set[3] = timer_b_overflow_flag;
    end

    // request lines in precedence order
    always_comb begin
        raw_req     = '0;
        raw_req[0]  = st.hw_pend[0];
        raw_req[1]  = st.hw_pend[1];
        raw_req[2]  = st.hw_pend[2];
        raw_req[3]  = st.hw_pend[3];
        raw_req[4]  = src.serial_rx_flag | src.serial_tx_flag;
        raw_req[5]  = src.timer_c_high_overflow
                    | src.timer_c_low_overflow;
        raw_req[6]  = src.sync_xfer_done_flag
                    | src.sync_write_collision
                    | src.sync_mode_fault
                    | src.sync_rx_overrun;
        raw_req[7]  = src.twowire_state_flag;
        raw_req[8]  = src.clock_alarm_flag;
        raw_req[9]  = src.conv_window_flag;
        raw_req[10] = src.conv_done_flag;
        raw_req[11] = src.counter_array_overflow
                    | (|src.counter_module_match_flag);
        raw_req[12] = src.comparator_fall_flag
                    | src.comparator_rise_flag;
        raw_req[13] = 1'b0;
        raw_req[14] = src.timer_d_high_overflow
                    | src.timer_d_low_overflow;
        raw_req[15] = ~src.supply_good_indicator;
        raw_req[16] = src.pin_match_hit;
        raw_req[17] = src.clock_osc_fail_flag;
        raw_req[18] = 1'b0;
        raw_req[19] = src.capsense_done_flag;
        raw_req[20] = src.capsense_compare_flag;
        raw_req[21] = src.capsense_scan_end_flag;
    end

    // enable and level bits: primary 6:0, ext one 7:0, ext two 6:0
    assign enable_vec = {st.mask2[6:0], st.mask1, st.mask0[6:0]};
    assign level_vec  = {st.level2[6:0], st.level1, st.level0[6:0]};

    // supply warning repeats while the supply stays low, until its enable bit or the global enable bit is cleared
    assign cand = raw_req & enable_vec
                & {`IVP_NUM_SRC{st.mask0[`IVP_GLOBAL_EN_BIT]}};

    // pick the lowest order at each level
    always_comb begin
        found_hi = 1'b0;
        found_lo = 1'b0;
        hi_idx   = '0;
        lo_idx   = '0;
        for (int i = `IVP_NUM_SRC - 1; i >= 0; i--) begin
            if (cand[i] && level_vec[i]) begin
                found_hi = 1'b1;
                hi_idx   = `IVP_ORD_W'(i);
            end
            if (cand[i] && !level_vec[i]) begin
                found_lo = 1'b1;
                lo_idx   = `IVP_ORD_W'(i);
            end
        end
    end

    // high level may interrupt a low-level routine, never the reverse
    always_comb begin
        grant      = 1'b0;
        grant_high = 1'b0;
        grant_idx  = '0;
        if (found_hi && !st.act_hi) begin
            grant      = 1'b1;
            grant_high = 1'b1;
            grant_idx  = hi_idx;
        end else if (found_lo && !st.act_hi && !st.act_lo) begin
            grant      = 1'b1;
            grant_high = 1'b0;
            grant_idx  = lo_idx;
        end
    end

    // hardware clear on vectoring, or software write-one-to-clear
    always_comb begin
        hw_clr = '0;
        if (irq_ack && st.req && st.req_order < `IVP_ORD_W'(`IVP_NUM_HW)) begin
            hw_clr[st.req_order[1:0]] = 1'b1;
        end
        if (reg_wr && reg_addr == `IVP_OFS_PEND0) begin
            hw_clr = hw_clr | (reg_wdata[`IVP_NUM_HW-1:0] & `IVP_WMASK_HWPEND);
        end
    end

    always_comb begin
        next_st = st;

        next_st.sync_a = {st.sync_a[0], ext_pin_req_a};
        next_st.sync_b = {st.sync_b[0], ext_pin_req_b};
        next_st.prev_a = st.sync_a[1];
        next_st.prev_b = st.sync_b[1];

        // a new event in the clearing cycle survives
        next_st.hw_pend = (st.hw_pend & ~hw_clr) | hw_set;

        if (reg_wr) begin
            case (reg_addr)
                `IVP_OFS_MASK0: begin
                    next_st.mask0 = reg_wdata & `IVP_WMASK_MASK0;
                end
                `IVP_OFS_LEVEL0: begin
                    next_st.level0 = reg_wdata & `IVP_WMASK_LEVEL0;
                end
                `IVP_OFS_MASK1: begin
                    next_st.mask1 = reg_wdata & `IVP_WMASK_EXT1;
                end
                `IVP_OFS_LEVEL1: begin
                    next_st.level1 = reg_wdata & `IVP_WMASK_EXT1;
                end
                `IVP_OFS_MASK2: begin
                    next_st.mask2 = reg_wdata & `IVP_WMASK_EXT2;
                end
                `IVP_OFS_LEVEL2: begin
                    next_st.level2 = reg_wdata & `IVP_WMASK_EXT2;
                end
                default: begin
                end
            endcase
        end

        next_st.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                `IVP_OFS_MASK0: begin
                    next_st.rdata = st.mask0;
                end
                `IVP_OFS_LEVEL0: begin
                    next_st.rdata = st.level0;
                end
                `IVP_OFS_MASK1: begin
                    next_st.rdata = st.mask1;
                end
                `IVP_OFS_LEVEL1: begin
                    next_st.rdata = st.level1;
                end
                `IVP_OFS_MASK2: begin
                    next_st.rdata = st.mask2;
                end
                `IVP_OFS_LEVEL2: begin
                    next_st.rdata = st.level2;
                end
                `IVP_OFS_PEND0: begin
                    next_st.rdata = raw_req[7:0];
                end
                `IVP_OFS_PEND1: begin
                    next_st.rdata = raw_req[15:8];
                end
                `IVP_OFS_PEND2: begin
                    next_st.rdata = {2'h0, raw_req[21:16]};
                end
                `IVP_OFS_SERVICE: begin
                    next_st.rdata = {st.act_hi, st.act_lo, st.req_high, st.req_order};
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end

        // return from a routine ends the highest level in service
        if (irq_return) begin
            if (st.act_hi) begin
                next_st.act_hi = 1'b0;
            end else begin
                next_st.act_lo = 1'b0;
            end
        end

        if (irq_ack && st.req) begin
            // core took the vector: enter service, drop the request a cycle
            if (st.req_high) begin
                next_st.act_hi = 1'b1;
            end else begin
                next_st.act_lo = 1'b1;
            end
            next_st.req = 1'b0;
            // the vector rests at zero whenever no request stands
            next_st.vector = `IVP_RESET_VECTOR;
        end else begin
            next_st.req       = grant;
            next_st.req_high  = grant_high;
            next_st.req_order = grant_idx;
            if (grant) begin
                next_st.vector = `IVP_VEC_BASE
                               + (16'(grant_idx) << `IVP_VEC_SHIFT);
            end else begin
                next_st.vector = `IVP_RESET_VECTOR;
            end
        end
    end

    // reset needs no flag: the vector rests at zero and nothing is served
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// ### core/ivp_pkg.sv
`include "ivp_regs.svh"

package ivp_pkg;

    // level flags held by the peripherals themselves
    typedef struct packed {
        logic                        serial_rx_flag;
        logic                        serial_tx_flag;
        logic                        timer_c_high_overflow;
        logic                        timer_c_low_overflow;
        logic                        sync_xfer_done_flag;
        logic                        sync_write_collision;
        logic                        sync_mode_fault;
        logic                        sync_rx_overrun;
        logic                        twowire_state_flag;
        logic                        clock_alarm_flag;
        logic                        conv_window_flag;
        logic                        conv_done_flag;
        logic                        counter_array_overflow;
        logic [`IVP_CCF_COUNT-1:0]   counter_module_match_flag;
        logic                        comparator_fall_flag;
        logic                        comparator_rise_flag;
        logic                        timer_d_high_overflow;
        logic                        timer_d_low_overflow;
        logic                        supply_good_indicator;
        logic                        pin_match_hit;
        logic                        clock_osc_fail_flag;
        logic                        capsense_done_flag;
        logic                        capsense_compare_flag;
        logic                        capsense_scan_end_flag;
    } ivp_src_t;

    typedef struct packed {
        logic [1:0]                  sync_a;
        logic [1:0]                  sync_b;
        logic                        prev_a;
        logic                        prev_b;
        logic [`IVP_NUM_HW-1:0]      hw_pend;
        logic [7:0]                  mask0;
        logic [7:0]                  level0;
        logic [7:0]                  mask1;
        logic [7:0]                  level1;
        logic [7:0]                  mask2;
        logic [7:0]                  level2;
        logic                        act_hi;
        logic                        act_lo;
        logic                        req;
        logic                        req_high;
        logic [`IVP_ORD_W-1:0]       req_order;
        logic [15:0]                 vector;
        logic [7:0]                  rdata;
    } ivp_state_t;

endpackage

// ### core/ivp_regs.svh
`ifndef IVP_REGS_SVH
`define IVP_REGS_SVH

// register offsets on the plain register port
`define IVP_ADDR_W          4
`define IVP_OFS_MASK0       4'h0
`define IVP_OFS_LEVEL0      4'h1
`define IVP_OFS_MASK1       4'h2
`define IVP_OFS_LEVEL1      4'h3
`define IVP_OFS_MASK2       4'h4
`define IVP_OFS_LEVEL2      4'h5
`define IVP_OFS_PEND0       4'h6
`define IVP_OFS_PEND1       4'h7
`define IVP_OFS_PEND2       4'h8
`define IVP_OFS_SERVICE     4'h9

// writable bits of each register
`define IVP_WMASK_MASK0     8'hff
`define IVP_WMASK_LEVEL0    8'h7f
`define IVP_WMASK_EXT1      8'hbf
`define IVP_WMASK_EXT2      8'h77
`define IVP_WMASK_HWPEND    4'hf

// field positions
`define IVP_GLOBAL_EN_BIT   7
`define IVP_NUM_SRC         22
`define IVP_NUM_HW          4
`define IVP_ORD_W           5
`define IVP_CCF_COUNT       3

// vector addresses: base plus order times eight
`define IVP_RESET_VECTOR    16'h0000
`define IVP_VEC_BASE        16'h0003
`define IVP_VEC_SHIFT       3

`endif
